// ### hw/shift_port_cfg.svh
// Purpose: Named constants for the three-wire serial shift port.
// Assumes: Included by its bare name from the package and the modules.
// Notes:   Field positions refer to the port pin configuration byte.
`ifndef SHIFT_PORT_CFG_SVH
`define SHIFT_PORT_CFG_SVH

`define SSP_BITS        8          // Bits per transfer
`define SSP_CNT_W       4          // Width of the bit counter
`define SSP_CNT_DONE    4'h8       // Count at which a transfer ends
`define SSP_CNT_ONE     4'h1       // Counter increment
`define SSP_CNT_ZERO    4'h0       // Counter cleared
`define CFG_CS_BIT      0          // Chip-select pin direction bit
`define CFG_SO_BIT      4          // Serial-out pin direction bit
`define CFG_SK_BIT      5          // Shift-clock pin direction bit
`define CFG_PHASE_BIT   6          // Serial-in pin bit, reused as phase select
`define CFG_RESET       8'h00      // Configuration after power-up
`define SR_RESET        8'h00      // Shift register after power-up
`define VEC_SHIFT       8'hF2      // Table entry offset, shift complete
`define VEC_CS          8'hF4      // Table entry offset, chip-select
`define VEC_RESET       8'h00      // Vector output after power-up
`define DIV_W           3          // Divider counter width
`define DIV_HALF_2      3'h1       // Half period, divide by 2
`define DIV_HALF_4      3'h2       // Half period, divide by 4
`define DIV_HALF_8      3'h4       // Half period, divide by 8
`define DIV_ONE         3'h1       // Divider increment
`define DIV_ZERO        3'h0       // Divider cleared

`endif

// ### hw/shift_port_pkg.sv
// Purpose: Types shared by the serial shift port modules.
// Assumes: shift_port_cfg.svh supplies widths.
// Notes:   Holds the phase enum and the main state struct.
`include "shift_port_cfg.svh"

package shift_port_pkg;

    // Shift-clock phase choice
    typedef enum logic {
        PH_NORMAL = 1'b0,                  // Sample on rise, drive on fall
        PH_ALT    = 1'b1                   // Sample on fall, drive on rise
    } phase_e;

    // All state of the port core
    typedef struct packed {
        logic [7:0]               cfg;       // Pin configuration byte
        logic [`SSP_BITS-1:0]     sr;        // Shift register
        logic                     samp;      // Serial-in sample, normal phase
        logic [`SSP_CNT_W-1:0]    cnt;       // Bits shifted so far
        logic                     busy;      // Transfer in progress
        logic                     so;        // Serial-out level
        logic                     so_oe;     // Serial-out enable
        logic                     sk_out;    // Master shift clock level
        logic                     sk_oe;     // Shift-clock enable
        logic                     sk_prev;   // Last synced shift clock
        logic                     cs_prev;   // Last synced chip select
        logic                     pend_shift;// Shift complete pending
        logic                     pend_cs;   // Chip-select pending
        logic                     irq;       // Interrupt request
        logic [7:0]               vec;       // Vector table offset
        logic                     vis_hit;   // Vector select answer
    } port_state_s;

endpackage : shift_port_pkg

// ### hw/pin_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/10ps
`include "shift_port_cfg.svh"

module pin_sync #(
    parameter int          W       = 3,     // Number of pins
    parameter logic [W-1:0] RST_VAL = '0    // Level held in reset
) (
    input  wire logic         clk,          // Core clock
    input  wire logic         arst_n,       // Async reset, active low
    input  wire logic [W-1:0] din,          // Raw pin levels
    output logic      [W-1:0] dout          // Synced levels
);
    typedef struct packed {
        logic [W-1:0] s1;                   // Metastable stage
        logic [W-1:0] s2;                   // Stable stage
    } sync_s;

    sync_s q;                               // Registered state
    sync_s d;                               // Next state

    // Next state: shift the pins through two stages
    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    // Register the state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= {RST_VAL, RST_VAL};
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;

endmodule : pin_sync

// ### hw/sk_divider.sv
// Purpose: Shift-clock generator for master mode.
// Assumes: Runs from the instruction-cycle clock.
// Notes:   Cleared and held low whenever run is low.
`timescale 1ns/10ps
`include "shift_port_cfg.svh"

module sk_divider (
    input  wire logic       clk,            // Instruction-cycle clock
    input  wire logic       arst_n,         // Async reset, active low
    input  wire logic       run,            // Transfer under way
    input  wire logic [1:0] sel,            // Divide select, hi then lo
    output logic            level,          // Shift clock level
    output logic            rise,           // Pulse with each rising level
    output logic            fall            // Pulse with each falling level
);
    typedef struct packed {
        logic [`DIV_W-1:0] cnt;             // Half-period counter
        logic              level;           // Clock level
        logic              rise;            // Rise pulse
        logic              fall;            // Fall pulse
    } div_s;

    div_s q;                                // Registered state
    div_s d;                                // Next state
    logic [`DIV_W-1:0] half;                // Cycles per half period
    logic [`DIV_W-1:0] cnt_nx;              // Incremented count

    // Divide by 2, 4 or 8; codes 00, 01, 1x
    always_comb begin
        d      = q;
        d.rise = 1'b0;
        d.fall = 1'b0;
        half   = sel[1] ? `DIV_HALF_8 : (sel[0] ? `DIV_HALF_4 : `DIV_HALF_2);
        cnt_nx = q.cnt + `DIV_ONE;
        if (!run) begin
            // Idle clock sits low so no runt edge leaves the port
            d.cnt   = `DIV_ZERO;
            d.level = 1'b0;
        end else if (cnt_nx == half) begin
            d.cnt   = `DIV_ZERO;
            d.level = ~q.level;
            d.rise  = ~q.level;
            d.fall  = q.level;
        end else begin
            d.cnt = cnt_nx;
        end
    end

    // Register the state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
    assign rise  = q.rise;
    assign fall  = q.fall;

endmodule : sk_divider

// ### hw/three_wire_serial_shift_port.sv
// Purpose: Eight-bit three-wire serial shift port, master or slave.
// Assumes: clk is the instruction-cycle clock; pins are asynchronous.
// Notes:   Software side is plain ports; serial-out and master shift-clock direction
//          follow the configuration byte, whose serial-in bit selects the phase.
`timescale 1ns/10ps
`include "shift_port_cfg.svh"

module three_wire_serial_shift_port
    import shift_port_pkg::*;
(
    input  wire logic       clk,                 // Instruction-cycle clock
    input  wire logic       arst_n,              // Async reset, active low
    input  wire logic       serial_port_enable,  // Gates port onto pins
    input  wire logic       master_mode,         // 1 master, 0 slave
    input  wire logic       clock_divide_sel_hi, // Divide select high bit
    input  wire logic       clock_divide_sel_lo, // Divide select low bit
    input  wire logic       cfg_wr,              // Pulse: write config byte
    input  wire logic [7:0] cfg_wdata,           // Config byte to write
    input  wire logic       load_wr,             // Pulse: load shift reg
    input  wire logic [7:0] load_data,           // Byte to send
    input  wire logic       busy_wr,             // Pulse: write busy flag
    input  wire logic       busy_wdata,          // Busy value to write
    input  wire logic       shift_int_en,        // Completion irq enable
    input  wire logic       cs_int_en,           // Chip-select irq enable
    input  wire logic       vis_exec,            // Pulse: vector select
    input  wire logic       cs_n_pin,            // Chip select, active low
    input  wire logic       sk_in,               // Shift clock pin input
    input  wire logic       si_pin,              // Serial in pin
    output logic            sk_out,              // Shift clock drive
    output logic            sk_oe,               // Shift clock enable
    output logic            so_out,              // Serial out drive
    output logic            so_oe,               // Serial out enable
    output logic [7:0]      shift_data_q,        // Shift register contents
    output logic            busy_q,              // Busy flag
    output logic [7:0]      port_cfg_q,          // Config byte readback
    output logic            clock_phase_select_q,// Phase flag readback
    output logic            shift_pend_q,        // Completion pending
    output logic            cs_pend_q,           // Chip-select pending
    output logic            irq_q,               // Interrupt request
    output logic [7:0]      vis_vector_q,        // Chosen table offset
    output logic            vis_hit_q            // Pulse: vector chosen
);
    port_state_s q;                              // Registered state
    port_state_s d;                              // Next state
    logic [2:0]  pin_s;                          // Synced cs, sk, si
    logic        cs_s;                           // Synced chip select
    logic        sk_s;                           // Synced shift clock
    logic        si_s;                           // Synced serial in
    logic        div_lvl;                        // Master clock level
    logic        div_rise;                       // Master rise pulse
    logic        div_fall;                       // Master fall pulse
    logic        run_m;                          // Master transfer running
    logic        edge_r;                         // Active rising edge
    logic        edge_f;                         // Active falling edge
    logic        active;                         // Shifting allowed
    phase_e      phase;                          // Current phase
    logic [`SSP_CNT_W-1:0] cnt_nx;               // Counter after a shift

    // Chip select idles high in reset so no false session starts
    pin_sync #(
        .W       (3),
        .RST_VAL (3'h4)
    ) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .din     ({cs_n_pin, sk_in, si_pin}),
        .dout    (pin_s)
    );

    assign cs_s = pin_s[2];
    assign sk_s = pin_s[1];
    assign si_s = pin_s[0];

    // Divider only runs during a master transfer
    assign run_m = q.busy & master_mode & serial_port_enable;

    sk_divider u_div (
        .clk     (clk),
        .arst_n  (arst_n),
        .run     (run_m),
        .sel     ({clock_divide_sel_hi, clock_divide_sel_lo}),
        .level   (div_lvl),
        .rise    (div_rise),
        .fall    (div_fall)
    );

    // Next-state logic for the whole port
    always_comb begin
        d         = q;
        d.vis_hit = 1'b0;
        d.sk_prev = sk_s;
        d.cs_prev = cs_s;
        cnt_nx    = q.cnt + `SSP_CNT_ONE;
        phase     = phase_e'(q.cfg[`CFG_PHASE_BIT]);
        // Edges come from the divider as master, from the pin as slave
        edge_r    = master_mode ? div_rise : (sk_s & ~q.sk_prev);
        edge_f    = master_mode ? div_fall : (~sk_s & q.sk_prev);
        // Slave shifts only while busy and selected; master frames by busy
        active    = q.busy & serial_port_enable
                  & (master_mode | ~cs_s);

        // Serial shifting
        if (active) begin
            case (phase)
                PH_NORMAL: begin
                    if (edge_r) begin
                        d.samp = si_s;
                    end
                    if (edge_f) begin
                        d.sr  = {q.sr[`SSP_BITS-2:0], q.samp};
                        d.so  = q.sr[`SSP_BITS-2];
                        d.cnt = cnt_nx;
                    end
                end
                PH_ALT: begin
                    if (edge_r) begin
                        d.so = q.sr[`SSP_BITS-1];
                    end
                    if (edge_f) begin
                        d.sr  = {q.sr[`SSP_BITS-2:0], si_s};
                        d.cnt = cnt_nx;
                    end
                end
                default: begin
                    d.cnt = q.cnt;
                end
            endcase
            // Received byte stays in the register for software
            if (edge_f && cnt_nx == `SSP_CNT_DONE) begin
                d.busy = 1'b0;
                d.cnt  = `SSP_CNT_ZERO;
            end
        end

        // Software writes win over a shift in the same cycle
        if (cfg_wr) begin
            d.cfg = cfg_wdata;
        end
        if (busy_wr) begin
            // Clearing early allows a short transfer
            d.busy = busy_wdata;
            d.cnt  = `SSP_CNT_ZERO;
        end
        if (load_wr) begin
            // Per-byte load must land before the master clocks again
            d.sr   = load_data;
            d.so   = load_data[`SSP_BITS-1];
            d.busy = 1'b1;
            d.cnt  = `SSP_CNT_ZERO;
        end

        // Pin drive follows enable and direction bits; shift clock only as master
        d.so_oe  = serial_port_enable & d.cfg[`CFG_SO_BIT];
        d.sk_oe  = serial_port_enable & d.cfg[`CFG_SK_BIT]
                 & master_mode;
        // Busy gate hides the divider's last toggle as busy drops
        d.sk_out = master_mode & q.busy & div_lvl;

        // Vector select: completion ranks above chip select
        if (vis_exec) begin
            if (q.pend_shift && shift_int_en) begin
                d.vec        = `VEC_SHIFT;
                d.vis_hit    = 1'b1;
                d.pend_shift = 1'b0;
            end else if (q.pend_cs && cs_int_en) begin
                d.vec     = `VEC_CS;
                d.vis_hit = 1'b1;
                d.pend_cs = 1'b0;
            end else begin
                d.vec = q.vec;
            end
        end

        // Sets come after clears so a coincident event is kept
        if (q.busy && !d.busy) begin
            d.pend_shift = 1'b1;
        end
        if (q.cs_prev && !cs_s) begin
            d.pend_cs = 1'b1;
        end
        d.irq = (d.pend_shift & shift_int_en)
              | (d.pend_cs & cs_int_en);
    end

    // Register the state; phase flag clears at power-up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q         <= '0;
            q.cfg     <= `CFG_RESET;
            q.sr      <= `SR_RESET;
            q.vec     <= `VEC_RESET;
            q.cs_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign sk_out               = q.sk_out;
    assign sk_oe                = q.sk_oe;
    assign so_out               = q.so;
    assign so_oe                = q.so_oe;
    assign shift_data_q         = q.sr;
    assign busy_q               = q.busy;
    assign port_cfg_q           = q.cfg;
    assign clock_phase_select_q = q.cfg[`CFG_PHASE_BIT];
    assign shift_pend_q         = q.pend_shift;
    assign cs_pend_q            = q.pend_cs;
    assign irq_q                = q.irq;
    assign vis_vector_q         = q.vec;
    assign vis_hit_q            = q.vis_hit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Chip select held low long enough to pass the synchroniser
    sequence cs_fall_seen;
        cs_n_pin ##1 !cs_n_pin [*4];
    endsequence
    sequence no_vis_5;
        !vis_exec [*5];
    endsequence

    // Load starts a transfer with the byte in place
    a_load_sets_busy: assert property (load_wr |=> busy_q
        && shift_data_q == $past(load_data))
        else $error("load did not start a transfer");
    // Only the eighth shift may end a transfer by itself
    a_busy_eighth_bit: assert property ($fell(busy_q) && !$past(busy_wr)
        |-> $past(q.cnt) == `SSP_CNT_DONE - `SSP_CNT_ONE)
        else $error("busy cleared at wrong bit count");
    // Counter never holds a full byte
    a_count_bound: assert property (q.cnt < `SSP_CNT_DONE)
        else $error("bit count ran past a byte");
    // Phase follows the serial-in configuration bit
    a_phase_from_cfg: assert property (cfg_wr |=>
        clock_phase_select_q == $past(cfg_wdata[`CFG_PHASE_BIT]))
        else $error("phase flag not taken from config bit");
    // Idle register ignores a toggling clock
    a_idle_holds_data: assert property (!busy_q && !load_wr && !busy_wr
        |=> $stable(shift_data_q))
        else $error("shift register moved while idle");
    a_done_pending: assert property ($fell(busy_q) |-> shift_pend_q)
        else $error("completion not pending");
    // Enables are registered together with the pending flags
    a_done_irq: assert property (shift_pend_q && $past(shift_int_en) |-> irq_q)
        else $error("enabled completion without irq");
    a_cs_irq: assert property (cs_pend_q && $past(cs_int_en) |-> irq_q)
        else $error("enabled chip select without irq");
    a_cs_pending: assert property (cs_fall_seen and no_vis_5 |-> cs_pend_q)
        else $error("chip select fall not pending");
    // A busy fall in the same cycle would set the flag again
    a_vector_pick: assert property (vis_exec && shift_pend_q && shift_int_en
        && !busy_q |=> vis_hit_q && vis_vector_q == `VEC_SHIFT && !shift_pend_q)
        else $error("wrong vector chosen");
    // Chip select is served once completion is out of the way
    a_cs_vector: assert property (vis_exec && !(shift_pend_q && shift_int_en)
        && cs_pend_q && cs_int_en |=> vis_hit_q && vis_vector_q == `VEC_CS)
        else $error("chip select vector not chosen");
    a_vis_quiet: assert property (!vis_exec |=> !vis_hit_q)
        else $error("vector chosen without a select");
    // Slave edges, normal phase: shift in the rise sample, drive on fall
    a_norm_shift_msb: assert property (busy_q && !master_mode && !cs_s
        && !clock_phase_select_q && edge_f && serial_port_enable
        && !load_wr && !busy_wr
        |=> shift_data_q[0] == $past(q.samp))
        else $error("normal phase shifted wrong bit");
    a_norm_drive_fall: assert property (busy_q && !master_mode && !cs_s
        && !clock_phase_select_q && edge_f && serial_port_enable
        && !load_wr && !busy_wr
        |=> so_out == $past(shift_data_q[6]))
        else $error("normal phase drove wrong bit");
    // Alternate phase: drive on rise in either mode, slave sample on fall
    a_alt_drive_rise: assert property (busy_q && !load_wr && !busy_wr
        && clock_phase_select_q && edge_r && active
        |=> so_out == $past(shift_data_q[7]))
        else $error("alternate phase drove wrong bit");
    a_alt_sample_fall: assert property (busy_q && !master_mode && !cs_s
        && clock_phase_select_q && edge_f && serial_port_enable
        && !load_wr && !busy_wr
        |=> shift_data_q[0] == $past(si_s))
        else $error("alternate phase sampled wrong bit");
    // Pin drive follows mode, enable and busy
    a_slave_sk_in: assert property (!master_mode |=> !sk_oe)
        else $error("slave drove the shift clock pin");
    a_so_gated: assert property (!serial_port_enable |=> !so_oe)
        else $error("serial out driven while port disabled");
    a_sk_idle_low: assert property (!busy_q |=> !sk_out)
        else $error("shift clock moved outside a transfer");

endmodule : three_wire_serial_shift_port

// ### test/ext_master.sv
// Purpose: External master driving chip select, shift clock, serial in.
// Assumes: Half period far above the slave's three-cycle pin delay.
// Notes:   Clock stands low outside frames; serial in inverts once released.
`timescale 1ns/10ps
module ext_master #(
    parameter int HALF_NS = 40,   // Shift-clock half period
    parameter int T_NS    = 200   // Agreed interval, plain default
) (
    output logic      cs_n,       // Chip select, active low
    output logic      sk,         // Shift clock
    output logic      si,         // Data towards the slave
    input  wire logic so          // Data from the slave
);
    // Idle levels at time zero
    initial begin
        cs_n = 1'b1;
        sk   = 1'b0;
        si   = 1'b0;
    end
    // Select, then give the slave time to prepare
    task automatic open_frame();
        cs_n = 1'b0;
        #(T_NS);
    endtask : open_frame
    // Deselect ends the session
    task automatic close_frame();
        cs_n = 1'b1;
        si   = ~si;
    endtask : close_frame
    // One byte MSB first; si moves on the edge the slave does not sample on
    task automatic xfer(input logic [7:0] tx, input logic alt, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (!alt) si = tx[i];
            #(HALF_NS);
            if (!alt) rx[i] = so;
            sk = 1'b1;
            if (alt) si = tx[i];
            #(HALF_NS);
            if (alt) rx[i] = so;
            sk = 1'b0;
        end
        #(HALF_NS);
        si = ~si;  // Hold over, stale level not kept
        #(T_NS);
    endtask : xfer
endmodule : ext_master

// ### test/testbench.sv
// Purpose: Self-checking bench for the serial shift port.
// Assumes: ext_master plays the far side in slave tests.
// Notes:   Chip-select irq enable tied high; busy writes unused.
`timescale 1ns/10ps
module testbench;
    import shift_port_pkg::*;
    logic clk, arst_n, en, mst, shi, slo, cfg_wr, load_wr, vis_exec;
    logic [7:0] cfg_wdata, load_data, rx, sd, cfg, vec;
    logic sk_out, sk_oe, so_out, so_oe, busy, ph, spend, cpend, irq, hit;
    logic cs_n, sk_m, si_m, sie;
    wire  so_w = so_oe ? so_out : 1'bz;   // Undriven line floats at high impedance
    int   bad_count, n_tests;
    ext_master m (.cs_n(cs_n), .sk(sk_m), .si(si_m), .so(so_w));
    three_wire_serial_shift_port dut (
        .clk(clk), .arst_n(arst_n), .serial_port_enable(en), .master_mode(mst),
        .clock_divide_sel_hi(shi), .clock_divide_sel_lo(slo),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .load_wr(load_wr),
        .load_data(load_data), .busy_wr(1'b0), .busy_wdata(1'b0),
        .shift_int_en(sie), .cs_int_en(1'b1), .vis_exec(vis_exec),
        .cs_n_pin(cs_n), .sk_in(sk_m), .si_pin(si_m), .sk_out(sk_out),
        .sk_oe(sk_oe), .so_out(so_out), .so_oe(so_oe), .shift_data_q(sd),
        .busy_q(busy), .port_cfg_q(cfg), .clock_phase_select_q(ph),
        .shift_pend_q(spend), .cs_pend_q(cpend), .irq_q(irq),
        .vis_vector_q(vec), .vis_hit_q(hit));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Comparisons, one per result width
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t byte got %h want %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t flag got %b want %b", $time, g, e);
        end
    endtask : chk1
    // One-cycle software pulses
    task automatic wr_cfg(input logic [7:0] d);
        cfg_wdata = d;
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(1);
    endtask : wr_cfg
    task automatic load(input logic [7:0] d);
        load_data = d;
        load_wr = 1'b1;
        tick(1);
        load_wr = 1'b0;
    endtask : load
    task automatic vector_select_instruction();
        vis_exec = 1'b1;
        tick(1);
        vis_exec = 1'b0;
        chk1(hit, 1'b1);
        tick(2);
    endtask : vector_select_instruction
    // Bounded wait for the transfer end
    task automatic wait_idle();
        for (int i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
        chk1(busy, 1'b0);
    endtask : wait_idle
    // Master run: count high cycles and rising edges of the clock
    task automatic mst_run(input logic [1:0] s, input int half);
        int h, n;
        logic p;
        h = 0;
        n = 0;
        p = 1'b0;
        {shi, slo} = s;
        load(8'h81);
        for (int i = 0; i < 200; i++) begin
            if (sk_out === 1'b1 && p === 1'b0) n++;
            if (sk_out === 1'b1) h++;
            p = sk_out;
            if (busy === 1'b0) break;
            tick(1);
        end
        chk8(8'(n), 8'h08);
        chk8(8'(h), 8'(8 * half));
        chk1(busy, 1'b0);
        tick(1);
        chk1(sk_out, 1'b0);
    endtask : mst_run
    // Counts and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    // Watchdog well past the expected run
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
    // Main sequence
    initial begin
        {arst_n, en, mst, shi, slo, cfg_wr, load_wr, vis_exec} = '0;
        cfg_wdata = 8'h00;
        load_data = 8'h00;
        sie = 1'b1;
        bad_count = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        #1 arst_n = 1'b1;
        tick(1);
        chk8(cfg, 8'h00);
        chk1(ph, 1'b0);
        $display("test reset done");
        en = 1'b1;
        wr_cfg(8'h10);
        chk1(so_oe, 1'b1);
        chk1(sk_oe, 1'b0);
        m.open_frame();
        chk1(cpend, 1'b1);
        chk1(irq, 1'b1);
        m.xfer(8'hFF, 1'b0, rx);
        chk8(sd, 8'h00);
        $display("test idle clock done");
        load(8'hA5);
        m.xfer(8'h3C, 1'b0, rx);
        wait_idle();
        chk8(sd, 8'h3C);
        chk8(rx, 8'hA5);
        chk1(spend, 1'b1);
        vector_select_instruction();
        chk8(vec, 8'hF2);
        chk1(spend, 1'b0);
        vector_select_instruction();
        chk8(vec, 8'hF4);
        chk1(irq, 1'b0);
        m.close_frame();
        $display("test normal phase done");
        wr_cfg(8'h50);
        chk1(ph, 1'b1);
        m.open_frame();
        load(8'h5A);
        m.xfer(8'hC3, 1'b1, rx);
        wait_idle();
        chk8(sd, 8'hC3);
        chk8(rx, 8'h5A);
        chk1(irq, 1'b1);
        vector_select_instruction();
        chk8(vec, 8'hF2);
        vector_select_instruction();
        chk8(vec, 8'hF4);
        chk1(irq, 1'b0);
        m.close_frame();
        $display("test alternate phase done");
        mst = 1'b1;
        wr_cfg(8'h30);
        chk1(sk_oe, 1'b1);
        sie = 1'b0;
        mst_run(2'b00, 1);
        chk1(spend, 1'b1);
        chk1(irq, 1'b0);
        sie = 1'b1;
        tick(1);
        chk1(irq, 1'b1);
        mst_run(2'b01, 2);
        mst_run(2'b10, 4);
        mst_run(2'b11, 4);
        $display("test master divide done");
        test_done();
    end
endmodule : testbench
